// File: rtl/vim_monitor.sv
// Voltage-id monitor, shared pin select, change alert and value registers
module vim_monitor #(
    parameter int CONV_CYCLES = vim_pkg::CONV_CYC
) (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    // Identification pins, bit 5 is the shared pin
    input  wire logic [vim_pkg::ID_BITS-1:0] id_pins_in,
    // Converter side
    input  wire logic [vim_pkg::RAW_BITS-1:0] adc_raw_in,
    input  wire logic                        supply_limit_in,
    output logic                             adc_strobe_out,
    output logic [2:0]                       adc_channel_out,
    output logic                             vcc_5v_scale_out,
    output logic                             id_threshold_low_out,
    output logic                             shared_pin_is_id_out,
    // Register access port
    input  wire logic [7:0]                  reg_addr_in,
    input  wire logic                        reg_wr_in,
    input  wire logic [7:0]                  reg_wdata_in,
    output logic [7:0]                       reg_rdata_out,
    // Alert open-drain pin
    input  wire logic                        alert_in,
    output logic                             alert_o_out,
    output logic                             alert_oe_out
);
    import vim_pkg::*;

    localparam int CW = $clog2(CONV_CYCLES);
    localparam int WW = $clog2(ID_WINDOW_CYC);

    function automatic logic [CODE_BITS-1:0] sat_code(
        input logic [RAW_BITS-1:0] raw);
        if (raw[RAW_BITS-1])
            return '0;
        else if (raw[RAW_BITS-2:0] > (RAW_BITS-1)'(CODE_MAX))
            return CODE_MAX;
        else
            return raw[CODE_BITS-1:0];
    endfunction

    vim_avg_if avg_bus ();

    // Synchronisers
    logic [ID_BITS-1:0]   meta_q, meta_d, sync_q, sync_d;
    // Change detection
    logic [ID_BITS-1:0]   snap_q, snap_d;
    logic [WW-1:0]        win_q, win_d;
    logic                 flag_q, flag_d;
    // Configuration
    logic [7:0]           id_reg_q, id_reg_d;
    logic [7:0]           cfg1_q, cfg1_d;
    logic [7:0]           cfg2_q, cfg2_d;
    logic [7:0]           mask2_q, mask2_d;
    // Conversion sequencing and values
    logic [CW-1:0]        conv_q, conv_d;
    logic                 strobe_q, strobe_d;
    logic [2:0]           chan_q, chan_d;
    logic [CODE_BITS-1:0] value_q [NUM_CHAN];
    logic [CODE_BITS-1:0] value_d [NUM_CHAN];
    logic                 sel;

    assign sel = id_reg_q[SEL_BIT];

    always_comb begin
        meta_d = id_pins_in;
        sync_d = meta_q;
    end

    // 11 us comparison window
    always_comb begin
        win_d  = win_q;
        snap_d = snap_q;
        flag_d = flag_q;
        if (win_q == WW'(ID_WINDOW_CYC - 1)) begin
            win_d  = '0;
            snap_d = sync_q;
        end else begin
            win_d = win_q + WW'(1);
        end
        flag_d = sel && (sync_q != snap_q);
    end

    // Register writes
    always_comb begin
        id_reg_d = id_reg_q;
        cfg1_d   = cfg1_q;
        cfg2_d   = cfg2_q;
        mask2_d  = mask2_q;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                ID_INPUTS_ADDR:    id_reg_d = reg_wdata_in & ID_WR_MASK;
                CONFIG_ONE_ADDR:   cfg1_d = reg_wdata_in & CONFIG_ONE_MASK;
                CONFIG_TWO_ADDR:   cfg2_d = reg_wdata_in & CONFIG_TWO_MASK;
                INT_MASK_TWO_ADDR: mask2_d = reg_wdata_in;
                default:           ;
            endcase
        end
    end

    // Conversion pacing and channel rotation
    always_comb begin
        conv_d   = conv_q;
        strobe_d = 1'b0;
        chan_d   = chan_q;
        value_d  = value_q;
        if (conv_q == CW'(CONV_CYCLES - 1)) begin
            conv_d   = '0;
            strobe_d = 1'b1;
        end else begin
            conv_d = conv_q + CW'(1);
        end
        if (avg_bus.result_valid) begin
            value_d[chan_q] = avg_bus.result_code;
            chan_d = (chan_q == 3'(NUM_CHAN - 1)) ? 3'h0 : chan_q + 3'h1;
        end
    end

    assign avg_bus.sample_valid = strobe_q;
    assign avg_bus.sample_code  = sat_code(adc_raw_in);
    assign avg_bus.avg_off      = cfg2_q[AVG_OFF_BIT];

    vim_averager u_avg (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .avg_io  (avg_bus)
    );

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q   <= '0;
            sync_q   <= '0;
            snap_q   <= '0;
            win_q    <= '0;
            flag_q   <= 1'b0;
            id_reg_q <= REG_RESET;
            cfg1_q   <= REG_RESET;
            cfg2_q   <= REG_RESET;
            mask2_q  <= REG_RESET;
            conv_q   <= '0;
            strobe_q <= 1'b0;
            chan_q   <= '0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                value_q[i] <= '0;
            end
        end else begin
            meta_q   <= meta_d;
            sync_q   <= sync_d;
            snap_q   <= snap_d;
            win_q    <= win_d;
            flag_q   <= flag_d;
            id_reg_q <= id_reg_d;
            cfg1_q   <= cfg1_d;
            cfg2_q   <= cfg2_d;
            mask2_q  <= mask2_d;
            conv_q   <= conv_d;
            strobe_q <= strobe_d;
            chan_q   <= chan_d;
            value_q  <= value_d;
        end
    end

    // Register reads
    always_comb begin
        reg_rdata_out = 8'h00;
        if (reg_addr_in >= VALUE_BASE_ADDR &&
            reg_addr_in < VALUE_BASE_ADDR + 8'(NUM_CHAN)) begin
            reg_rdata_out = value_q[3'(reg_addr_in - VALUE_BASE_ADDR)]
                                   [CODE_BITS-1:CODE_BITS-8];
        end else begin
            unique case (reg_addr_in)
                ID_INPUTS_ADDR: begin
                    reg_rdata_out[4:0] = sync_q[4:0];
                    reg_rdata_out[SIXTH_ID_BIT] =
                        sel & sync_q[SIXTH_ID_BIT];
                    reg_rdata_out[THLD_BIT] = id_reg_q[THLD_BIT];
                    reg_rdata_out[SEL_BIT]  = sel;
                end
                STATUS_TWO_ADDR:
                    reg_rdata_out[FLAG_BIT] =
                        sel ? flag_q : supply_limit_in;
                CONFIG_ONE_ADDR:   reg_rdata_out = cfg1_q;
                CONFIG_TWO_ADDR:   reg_rdata_out = cfg2_q;
                INT_MASK_TWO_ADDR: reg_rdata_out = mask2_q;
                default:           reg_rdata_out = 8'h00;
            endcase
        end
    end

    assign adc_strobe_out       = strobe_q;
    assign adc_channel_out      = chan_q;
    assign vcc_5v_scale_out     = cfg1_q[VCC5_BIT];
    assign id_threshold_low_out = id_reg_q[THLD_BIT];
    assign shared_pin_is_id_out = sel;
    assign alert_o_out          = 1'b0;
    assign alert_oe_out         = flag_q & ~mask2_q[MASK_BIT];
endmodule // vim_monitor

// File: common/vim_pkg.sv
// Constants shared by the voltage-id monitor and its averager
package vim_pkg;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          ID_WINDOW_NS    = 11000;
    localparam int          ID_WINDOW_CYC   = ID_WINDOW_NS / CLK_PERIOD_NS;
    localparam int          CONV_TIME_NS    = 711000;
    localparam int          CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int          ID_BITS         = 6;
    localparam int          CODE_BITS       = 10;
    localparam int          RAW_BITS        = 12;
    localparam int          AVG_COUNT       = 16;
    localparam int          AVG_SHIFT       = 4;
    localparam int          NUM_CHAN        = 5;
    localparam logic [9:0]  CODE_MAX        = 10'h3FF;
    localparam logic [9:0]  CODE_NOMINAL    = 10'h300;
    // Register offsets
    localparam logic [7:0]  VALUE_BASE_ADDR = 8'h20;
    localparam logic [7:0]  CONFIG_ONE_ADDR = 8'h40;
    localparam logic [7:0]  STATUS_TWO_ADDR = 8'h42;
    localparam logic [7:0]  ID_INPUTS_ADDR  = 8'h43;
    localparam logic [7:0]  CONFIG_TWO_ADDR = 8'h73;
    localparam logic [7:0]  INT_MASK_TWO_ADDR = 8'h75;
    // Field positions
    localparam int          SEL_BIT         = 7;
    localparam int          THLD_BIT        = 6;
    localparam int          SIXTH_ID_BIT    = 5;
    localparam int          FLAG_BIT        = 0;
    localparam int          MASK_BIT        = 0;
    localparam int          VCC5_BIT        = 7;
    localparam int          AVG_OFF_BIT     = 4;
    localparam logic [7:0]  ID_WR_MASK      = 8'hC0;
    localparam logic [7:0]  CONFIG_ONE_MASK = 8'hC0;
    localparam logic [7:0]  CONFIG_TWO_MASK = 8'h70;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [2:0]  CHAN_SUPPLY     = 3'h2;
endpackage

// File: common/vim_avg_if.sv
// Sample and result path between the monitor and its averager
interface vim_avg_if;
    logic                       sample_valid;
    logic [vim_pkg::CODE_BITS-1:0] sample_code;
    logic                       avg_off;
    logic                       result_valid;
    logic [vim_pkg::CODE_BITS-1:0] result_code;
    modport src (output sample_valid, output sample_code, output avg_off,
                 input result_valid, input result_code);
    modport avg (input sample_valid, input sample_code, input avg_off,
                 output result_valid, output result_code);
endinterface

// File: rtl/vim_averager.sv
// Conversion averager: sixteen-sample mean or single pass-through
module vim_averager
    import vim_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // Sample path
    vim_avg_if.avg    avg_io
);
    logic [13:0]          acc_q, acc_d;
    logic [3:0]           cnt_q, cnt_d;
    logic                 vld_q, vld_d;
    logic [CODE_BITS-1:0] res_q, res_d;
    logic [13:0]          sum;

    always_comb begin
        sum   = acc_q + 14'(avg_io.sample_code);
        acc_d = acc_q;
        cnt_d = cnt_q;
        vld_d = 1'b0;
        res_d = res_q;
        if (avg_io.sample_valid) begin
            if (avg_io.avg_off) begin
                res_d = avg_io.sample_code;
                vld_d = 1'b1;
                acc_d = '0;
                cnt_d = '0;
            end else if (cnt_q == 4'(AVG_COUNT - 1)) begin
                res_d = CODE_BITS'(sum >> AVG_SHIFT);
                vld_d = 1'b1;
                acc_d = '0;
                cnt_d = '0;
            end else begin
                acc_d = sum;
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_q <= '0;
            cnt_q <= '0;
            vld_q <= 1'b0;
            res_q <= '0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            vld_q <= vld_d;
            res_q <= res_d;
        end
    end

    assign avg_io.result_valid = vld_q;
    assign avg_io.result_code  = res_q;
endmodule // vim_averager

// File: sim/vim_monitor_chk.sv
// Port checker for the voltage-id monitor
module vim_chk (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       nrst_in,
    // Watched ports
    input wire logic [5:0] id_pins_in,
    input wire logic       supply_limit_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       shared_pin_is_id_out,
    input wire logic       vcc_5v_scale_out,
    input wire logic       alert_o_out,
    input wire logic       alert_oe_out
);
    import vim_pkg::*;
    logic        mask_q, mask_d;
    logic [5:0]  pins_q;
    logic [11:0] quiet_q, quiet_d;
    // Alert mask copy and cycles the id pins stood still
    always_comb begin
        mask_d  = (reg_wr_in && reg_addr_in == 8'h75) ? reg_wdata_in[0] : mask_q;
        quiet_d = (id_pins_in != pins_q) ? 12'h000 : quiet_q + 12'h001;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_q  <= 1'h0;
            pins_q  <= 6'h00;
            quiet_q <= 12'h000;
        end else begin
            mask_q  <= mask_d;
            pins_q  <= id_pins_in;
            quiet_q <= quiet_d;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_sel_taken: assert property (
        reg_wr_in && reg_addr_in == 8'h43 |=>
        shared_pin_is_id_out == $past(reg_wdata_in[7])) else $error("sel");
    a_bit5_zero: assert property (
        !shared_pin_is_id_out && reg_addr_in == 8'h43 |-> !reg_rdata_out[5])
        else $error("bit5 not zero");
    a_supply_flag: assert property (
        !shared_pin_is_id_out && reg_addr_in == 8'h42 |->
        reg_rdata_out[0] == supply_limit_in) else $error("supply flag");
    a_bit5_pin: assert property (
        shared_pin_is_id_out && reg_addr_in == 8'h43 && $past(nrst_in, 2) |->
        reg_rdata_out[5] == $past(id_pins_in[5], 2)) else $error("bit5 pin");
    a_low_bits: assert property (
        reg_addr_in == 8'h43 && $past(nrst_in, 2) |->
        reg_rdata_out[4:0] == $past(id_pins_in[4:0], 2)) else $error("id");
    a_flag_alert: assert property (
        shared_pin_is_id_out && reg_addr_in == 8'h42 |->
        alert_oe_out == (reg_rdata_out[0] && !mask_q)) else $error("alert");
    a_idle_quiet: assert property (
        !shared_pin_is_id_out && !$past(shared_pin_is_id_out) |->
        !alert_oe_out) else $error("alert with sel clear");
    a_flag_clears: assert property (
        quiet_q > 12'h89D |-> !alert_oe_out) else $error("flag stuck");
    a_scale_taken: assert property (
        reg_wr_in && reg_addr_in == 8'h40 |=>
        vcc_5v_scale_out == $past(reg_wdata_in[7])) else $error("scale");
    a_alert_level: assert property (
        !alert_o_out) else $error("alert drive level");
endmodule // vim_chk

bind vim_monitor vim_chk u_chk (
    .clk_in, .nrst_in, .id_pins_in, .supply_limit_in, .reg_addr_in,
    .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .shared_pin_is_id_out,
    .vcc_5v_scale_out, .alert_o_out, .alert_oe_out);

// File: sim/vim_vid_src.sv
// Regulator model driving the identification pins
module vim_vid_src (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [5:0] code_in,
    output logic      [5:0] pins_out
);
    import vim_pkg::*;
    // Pins move only on the clock edge, like a regulator output register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pins_out <= 6'h00;
        end else begin
            pins_out <= code_in;
        end
    end
endmodule // vim_vid_src

// File: sim/testbench.sv
// Self-checking bench for the voltage-id monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import vim_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic       w;
        logic [7:0] d;
        logic [5:0] p;
        logic       l;
        logic [7:0] m;
        logic [7:0] e;
    } vim_row_t;
    vim_row_t    rows [8] = '{
        '{8'h20, 1'h0, 8'h00, 6'h00, 1'h0, 8'hFF, 8'h00},
        '{8'h75, 1'h0, 8'h00, 6'h00, 1'h0, 8'hFF, 8'h00},
        '{8'h43, 1'h1, 8'h00, 6'h3F, 1'h0, 8'hFF, 8'h1F},
        '{8'h42, 1'h0, 8'h00, 6'h3F, 1'h1, 8'h01, 8'h01},
        '{8'h43, 1'h1, 8'h80, 6'h3F, 1'h0, 8'hFF, 8'hBF},
        '{8'h50, 1'h0, 8'h00, 6'h15, 1'h0, 8'hFF, 8'h00},
        '{8'h40, 1'h1, 8'h80, 6'h15, 1'h0, 8'hC0, 8'h80},
        '{8'h73, 1'h1, 8'h10, 6'h15, 1'h0, 8'h70, 8'h10}};
    logic [11:0] raws [3] = '{12'h300, 12'h7FF, 12'h800};
    logic [7:0]  exps [3] = '{8'hC0, 8'hFF, 8'h00};
    logic        clk_in, nrst_in, supply_limit_in, reg_wr_in, alt;
    logic        adc_strobe_out, alert_oe_out;
    logic [5:0]  code, id_pins_in;
    logic [11:0] adc_raw_in, raw_base, flip;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, got;
    int          err_count, checks_done;
    vim_vid_src u_src (.clk_in, .nrst_in, .code_in(code),
        .pins_out(id_pins_in));
    vim_monitor #(.CONV_CYCLES(20)) u_dut (
        .clk_in, .nrst_in, .id_pins_in, .adc_raw_in, .supply_limit_in,
        .adc_strobe_out, .adc_channel_out(), .vcc_5v_scale_out(),
        .id_threshold_low_out(), .shared_pin_is_id_out(), .reg_addr_in,
        .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
        .alert_in(!alert_oe_out), .alert_o_out(), .alert_oe_out);
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    // Alternate the converter input on every sample
    always @(posedge clk_in) begin
        if (!alt) begin
            flip <= 12'h000;
        end else if (adc_strobe_out) begin
            flip <= flip ^ 12'h200;
        end
    end
    assign adc_raw_in = raw_base ^ flip;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wr_in    <= w;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'h0;
    endtask
    task automatic poll(output logic [7:0] r);
        r = 8'h00;
        repeat (8) begin
            @(posedge clk_in);
            #1 r = r | {6'h00, reg_rdata_out[0], alert_oe_out};
        end
    endtask
    task automatic rd_vals(input logic [7:0] e);
        for (int c = 0; c < 5; c++) begin
            acc(8'h20 + 8'(c), 1'h0, 8'h00);
            #1 chk(reg_rdata_out, e);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        wrap_up();
    end
    initial begin
        {nrst_in, supply_limit_in, reg_wr_in, alt} = 4'h0;
        {err_count, checks_done, code} = '0;
        {reg_addr_in, reg_wdata_in, raw_base} = '0;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'h1;
        foreach (rows[i]) begin
            @(posedge clk_in);
            code            <= rows[i].p;
            supply_limit_in <= rows[i].l;
            acc(rows[i].a, rows[i].w, rows[i].d);
            repeat (4) @(posedge clk_in);
            #1 chk(reg_rdata_out & rows[i].m, rows[i].e);
        end
        repeat (1200) @(posedge clk_in);
        acc(8'h42, 1'h0, 8'h00);
        #1 chk({7'h00, alert_oe_out}, 8'h00);
        @(posedge clk_in);
        code <= 6'h2A;
        poll(got);
        chk(got, 8'h03);
        acc(8'h75, 1'h1, 8'h01);
        acc(8'h42, 1'h0, 8'h00);
        code <= 6'h15;
        poll(got);
        chk(got, 8'h02);
        repeat (2300) @(posedge clk_in);
        #1 chk(reg_rdata_out & 8'h01, 8'h00);
        acc(8'h43, 1'h1, 8'h00);
        acc(8'h75, 1'h1, 8'h00);
        acc(8'h42, 1'h0, 8'h00);
        code <= 6'h3F;
        poll(got);
        chk(got, 8'h00);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_in);
            raw_base <= raws[k];
            repeat (130) @(posedge clk_in);
            rd_vals(exps[k]);
        end
        acc(8'h73, 1'h1, 8'h00);
        raw_base   <= 12'h300;
        alt        <= 1'h1;
        repeat (3300) @(posedge clk_in);
        rd_vals(8'h80);
        // Reset in mid-run clears select and synchronisers
        @(posedge clk_in);
        nrst_in     <= 1'h0;
        reg_addr_in <= 8'h43;
        repeat (2) @(posedge clk_in);
        #1 chk(reg_rdata_out, 8'h00);
        chk({7'h00, alert_oe_out}, 8'h00);
        @(posedge clk_in);
        nrst_in <= 1'h1;
        repeat (4) @(posedge clk_in);
        #1 chk(reg_rdata_out, 8'h1F);
        wrap_up();
    end
endmodule // testbench
